// ===== lts_regs.vh
// Register map and field constants for the loop-through monitor select block
//
// Contract
// - Two-bit swing field sets transmit swing 190/275/325/375 mV; resets to 00.
// - While the select field is 00 or 11, monitor select bit 0 routes first input, 1 routes second input.
// - Loop-through driver off after reset; drives only while enable bit is 1.
// - Monitor select field 01 routes first input, 10 routes second input.
// - With second port chosen, port-specific writes update the second copy.
`ifndef LTS_REGS_VH
`define LTS_REGS_VH

// ----------------------------------------------------------------
// Offsets (register index; byte address is four times this)
// ----------------------------------------------------------------
`define LTS_IDX_SWING    8'h4b
`define LTS_IDX_MONA     8'h52
`define LTS_IDX_MONEN    8'h56
`define LTS_IDX_MONB     8'h57
`define LTS_IDX_PORTSEL  8'h80

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define LTS_RST_SWING    8'h08
`define LTS_RST_ZERO     8'h00
`define LTS_MONA_BIT     7
`define LTS_MONEN_BIT    3
`define LTS_MONB_HI      2
`define LTS_MONB_LO      1
`define LTS_SEL_FIRST    2'h1
`define LTS_SEL_SECOND   2'h2
`define LTS_PORTSEL_BIT  0

`endif

// ===== lts_monitor.v
// APB register slice for output swing and loop-through monitor routing
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lts_regs.vh"

module lts_monitor
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        first_serial_input,
  input  wire        second_serial_input,
  output reg         loopthrough_output,
  output reg         loopthrough_output_en,
  output wire [1:0]  swing_first_port,
  output wire [1:0]  swing_second_port
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg  [7:0] swing0_q;
  reg  [7:0] swing1_q;
  reg        mona_q;
  reg        monen_q;
  reg  [1:0] monb_q;
  reg        port_choose_q;
  reg  [1:0] in0_sync_q;
  reg  [1:0] in1_sync_q;

  wire [7:0] idx     = paddr[9:2];
  wire       wr_en   = psel & penable & pwrite;
  wire       mapped  = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                       ((idx == `LTS_IDX_SWING) || (idx == `LTS_IDX_MONA) ||
                        (idx == `LTS_IDX_MONEN) || (idx == `LTS_IDX_MONB) ||
                        (idx == `LTS_IDX_PORTSEL));
  wire       wr_hit  = wr_en & mapped;

  // Zero wait states; unmapped addresses error out
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  assign swing_first_port  = swing0_q[1:0];
  assign swing_second_port = swing1_q[1:0];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      swing0_q      <= `LTS_RST_SWING;
      swing1_q      <= `LTS_RST_SWING;
      mona_q        <= 1'b0;
      monen_q       <= 1'b0;
      monb_q        <= 2'h0;
      port_choose_q <= 1'b0;
    end
    else if (wr_hit)
    begin
      case (idx)
        `LTS_IDX_SWING:
        begin
          // Upper reserved bits are read-write storage only
          if (port_choose_q)
            swing1_q <= pwdata[7:0];
          else
            swing0_q <= pwdata[7:0];
        end
        `LTS_IDX_MONA:    mona_q        <= pwdata[`LTS_MONA_BIT];
        `LTS_IDX_MONEN:   monen_q       <= pwdata[`LTS_MONEN_BIT];
        `LTS_IDX_MONB:    monb_q        <= pwdata[`LTS_MONB_HI:`LTS_MONB_LO];
        `LTS_IDX_PORTSEL: port_choose_q <= pwdata[`LTS_PORTSEL_BIT];
        default:          port_choose_q <= port_choose_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read mux; read-only reserved bits return zero
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel & ~penable & ~pwrite)
    begin
      prdata <= 32'h0;
      case (idx)
        `LTS_IDX_SWING:   prdata[7:0] <= port_choose_q ? swing1_q : swing0_q;
        `LTS_IDX_MONA:    prdata[`LTS_MONA_BIT] <= mona_q;
        `LTS_IDX_MONEN:   prdata[`LTS_MONEN_BIT] <= monen_q;
        `LTS_IDX_MONB:    prdata[`LTS_MONB_HI:`LTS_MONB_LO] <= monb_q;
        `LTS_IDX_PORTSEL: prdata[`LTS_PORTSEL_BIT] <= port_choose_q;
        default:          prdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Loop-through routing
  // ----------------------------------------------------------------
  // Inputs are asynchronous; two-stage sync before routing
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      in0_sync_q            <= 2'h0;
      in1_sync_q            <= 2'h0;
      loopthrough_output    <= 1'b0;
      loopthrough_output_en <= 1'b0;
    end
    else
    begin
      in0_sync_q <= {in0_sync_q[0], first_serial_input};
      in1_sync_q <= {in1_sync_q[0], second_serial_input};
      // Field takes precedence when it holds a legal code; otherwise the bit decides.
      // Software must keep them consistent, so this only matters on misuse.
      if (monb_q == `LTS_SEL_FIRST)
        loopthrough_output <= in0_sync_q[1];
      else if (monb_q == `LTS_SEL_SECOND)
        loopthrough_output <= in1_sync_q[1];
      else
        loopthrough_output <= mona_q ? in1_sync_q[1] : in0_sync_q[1];
      loopthrough_output_en <= monen_q;
    end
  end

endmodule
`default_nettype wire

// ===== lts_link_src.sv
// Link data source driving both serial inputs
`timescale 1ns/1ps
`default_nettype none
module lts_link_src
(
  input  wire logic clk,
  output var  logic first_q = 1'b0,
  output var  logic second_q = 1'b0
);
  logic [4:0] cnt_q = 5'h0;
  // Distinct patterns so a wrong route shows
  always @(posedge clk)
  begin
    cnt_q    <= cnt_q + 5'h1;
    first_q  <= cnt_q[1];
    second_q <= cnt_q[3] ^ cnt_q[0];
  end
endmodule
`default_nettype wire

// ===== lts_monitor_properties.sv
// Concurrent checks for the monitor register slice
`timescale 1ns/1ps
`default_nettype none
module lts_monitor_properties
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        loopthrough_output_en,
  input wire logic [1:0]  swing_first_port
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_acc = psel && penable && !pwrite;
  wire en_wr = psel && penable && pwrite && paddr == 12'h158 && pwdata[3];
  rst_values_a:
    assert property ($rose(presetn) |-> !loopthrough_output_en && swing_first_port == 2'h0)
      else $error("Reset values wrong");
  drive_enable_a:
    assert property ($rose(loopthrough_output_en) |-> $past(en_wr) || $past(en_wr, 2))
      else $error("Driver on without enable write");
  reserved_ctl_a:
    assert property (rd_acc && paddr == 12'h148 |-> (prdata & 32'hffffff7f) == 32'h0)
      else $error("Reserved bits not zero");
  reserved_en_a:
    assert property (rd_acc && paddr == 12'h158 |-> (prdata & 32'hfffffff7) == 32'h0)
      else $error("Reserved enable bits not zero");
  swing_hold_a:
    assert property (!$past(psel && penable && pwrite && paddr == 12'h12c) |->
                     $stable(swing_first_port))
      else $error("Swing changed without a write");
  driver_off_a:
    assert property (psel && penable && pwrite && paddr == 12'h158 && !pwdata[3]
                     |=> ##1 !loopthrough_output_en)
      else $error("Driver still on after disable write");
  unmapped_err_a:
    assert property (psel && penable && paddr == 12'h100 |-> pslverr)
      else $error("No error on unmapped access");
endmodule
bind lts_monitor lts_monitor_properties i_lts_monitor_properties (.*);
`default_nettype wire

// ===== lts_monitor_test.sv
// Register and routing tests for the monitor slice
`timescale 1ns/1ps
`default_nettype none
module lts_monitor_test;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, in_a, in_b, lo, lo_en, err;
  logic [1:0]  sw0, sw1;
  logic [7:0]  h0 = 8'h0, h1 = 8'h0;
  int          failures = 0, compares = 0, cyc = 0;
  always #4 pclk = ~pclk;
  lts_link_src i_lts_link_src (.clk(pclk), .first_q(in_a), .second_q(in_b));
  lts_monitor i_lts_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .first_serial_input(in_a), .second_serial_input(in_b),
    .loopthrough_output(lo), .loopthrough_output_en(lo_en), .swing_first_port(sw0),
    .swing_second_port(sw1));
  always @(negedge pclk)
  begin
    h0 <= {h0[6:0], in_a};
    h1 <= {h1[6:0], in_b};
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      complete_run;
    end
  end
  task automatic chk(input logic [31:0] s, e);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrd(input logic [11:0] a, input logic [7:0] d, e);
    xfer(1'b1, a, d);
    xfer(1'b0, a, 8'h0);
    chk(rd, {24'h0, e});
  endtask
  // Input history tap lags by the synchroniser depth plus the output register
  task automatic route(input logic b, input logic [1:0] f, input logic s);
    xfer(1'b1, 12'h148, {b, 7'h0});
    xfer(1'b1, 12'h15c, {5'h0, f, 1'b0});
    repeat (6) @(posedge pclk);
    repeat (8) @(negedge pclk) chk(lo, s ? h1[2] : h0[2]);
  endtask
  task automatic complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 12'h12c, 8'h0);
    chk(rd, 32'h8);
    chk(lo_en, 1'b0);
    for (int k = 0; k < 4; k++) wrd(12'h12c, 8'hc0 | k, 8'hc0 | k);
    chk(sw0, 2'h3);
    xfer(1'b1, 12'h200, 8'h1);
    wrd(12'h12c, 8'h01, 8'h01);
    chk({sw1, sw0}, 4'h7);
    xfer(1'b1, 12'h200, 8'h0);
    $display("swing test done");
    wrd(12'h148, 8'hff, 8'h80);
    wrd(12'h158, 8'hff, 8'h08);
    wrd(12'h15c, 8'hff, 8'h06);
    wrd(12'h100, 8'hff, 8'h00);
    chk(err, 1'b1);
    chk(lo_en, 1'b1);
    $display("reserved test done");
    route(1'b0, 2'h1, 1'b0);
    route(1'b1, 2'h2, 1'b1);
    route(1'b1, 2'h0, 1'b1);
    route(1'b0, 2'h0, 1'b0);
    xfer(1'b1, 12'h158, 8'h0);
    repeat (3) @(posedge pclk);
    chk(lo_en, 1'b0);
    $display("routing test done");
    complete_run;
  end
endmodule
`default_nettype wire
